// File: common/dle_consts.vh
`ifndef DLE_CONSTS_VH
`define DLE_CONSTS_VH

// register map of the configuration port
`define DLE_ADDR_W 12
`define DLE_ADDR_LATCH 12'h022
`define DLE_ADDR_ENABLE 12'h025
`define DLE_ADDR_LIVE 12'h026

// widths and reset values
`define DLE_DATA_W 8
`define DLE_LOOPS 3
`define DLE_EVT_W 6
`define DLE_LATCH_RST 6'h00
`define DLE_ENABLE_RST 6'h00
`define DLE_RDATA_RST 8'h00
`define DLE_RSVD_BITS 2'h0

// field positions: loop k holdover at 2k, lost lock at 2k+1
`define DLE_HOLD_POS(k) (2*(k))
`define DLE_UNLOCK_POS(k) (2*(k)+1)
`define DLE_LOOP0_HOLD 0
`define DLE_LOOP0_UNLOCK 1
`define DLE_LOOP1_HOLD 2
`define DLE_LOOP1_UNLOCK 3
`define DLE_LOOP2_HOLD 4
`define DLE_LOOP2_UNLOCK 5

`endif

// File: rtl/dle_sticky_bit.v
`timescale 1ns/100ps
module dle_sticky_bit (
    // clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // set and clear strobes
    input wire set_i,
    input wire clr_i,
    // latched state
    output reg q_o
);

    // set outranks a clear in the same cycle so no event is lost
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            q_o <= 1'b0;
        end else begin
            q_o <= set_i | (q_o & ~clr_i);
        end
    end

endmodule // dle_sticky_bit

// File: rtl/dle_event_latch.v
`timescale 1ns/100ps
`include "dle_consts.vh"

// Notes on behaviour
// - enabled loss of lock sets odd bit
// - enabled holdover entry sets even bit
// - any latched event still enabled raises interrupt request
// - latched bits stay until software clears
// - live unlatched loop states readable separately
// - disabled events never latch nor interrupt
module dle_event_latch (
    // clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // live indicators from the loop state machines, same clock
    input wire [`DLE_LOOPS-1:0] loop_locked_i,
    input wire [`DLE_LOOPS-1:0] loop_holdover_i,
    // configuration port
    input wire [`DLE_ADDR_W-1:0] reg_addr_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [`DLE_DATA_W-1:0] reg_wdata_i,
    output reg [`DLE_DATA_W-1:0] reg_rdata_o,
    // interrupt request
    output reg irq_o
);

    // edge history of the live indicators
    reg [`DLE_LOOPS-1:0] locked_d;
    reg [`DLE_LOOPS-1:0] holdover_d;

    // software-visible state
    reg [`DLE_EVT_W-1:0] enable;
    reg [`DLE_EVT_W-1:0] next_enable;
    wire [`DLE_EVT_W-1:0] latch;
    wire [`DLE_EVT_W-1:0] live;

    // events before and after the enable gate, and software clears
    wire [`DLE_EVT_W-1:0] event_raw;
    wire [`DLE_EVT_W-1:0] event_set;
    wire [`DLE_EVT_W-1:0] event_clr;
    wire [`DLE_EVT_W-1:0] clr_mask;
    wire [`DLE_EVT_W-1:0] pending;
    reg next_irq;

    // named fields of the event latch
    wire loop0_hold_event;
    wire loop0_unlock_event;
    wire loop1_hold_event;
    wire loop1_unlock_event;
    wire loop2_hold_event;
    wire loop2_unlock_event;

    // address decode of the configuration port
    wire sel_latch;
    wire sel_enable;
    wire sel_live;
    wire sel_any;
    wire wr_latch;
    wire wr_enable;
    wire rd_latch;
    wire rd_enable;
    wire rd_live;
    wire rd_unmapped;
    wire [`DLE_EVT_W-1:0] wdata_evt;

    // read views with the reserved bits 7:6 held at zero
    wire [`DLE_DATA_W-`DLE_EVT_W-1:0] rsvd_zero;
    wire [`DLE_DATA_W-1:0] latch_view;
    wire [`DLE_DATA_W-1:0] enable_view;
    wire [`DLE_DATA_W-1:0] live_view;
    reg [`DLE_DATA_W-1:0] next_rdata;

    assign sel_latch = (reg_addr_i == `DLE_ADDR_LATCH);
    assign sel_enable = (reg_addr_i == `DLE_ADDR_ENABLE);
    assign sel_live = (reg_addr_i == `DLE_ADDR_LIVE);
    assign sel_any = sel_latch | sel_enable | sel_live;

    // the live status register has no write path, so writes to it fall away
    assign wr_latch = reg_wr_i & sel_latch;
    assign wr_enable = reg_wr_i & sel_enable;
    assign wdata_evt = reg_wdata_i[`DLE_EVT_W-1:0];
    assign clr_mask = ~wdata_evt;

    // a read alongside a write returns the value from before the write
    assign rd_latch = reg_rd_i & sel_latch;
    assign rd_enable = reg_rd_i & sel_enable;
    assign rd_live = reg_rd_i & sel_live;
    assign rd_unmapped = reg_rd_i & ~sel_any;

    // reset to unlocked, so a loop still acquiring after
    // reset is not taken for a loss of lock
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            locked_d <= {`DLE_LOOPS{1'b0}};
        end else begin
            locked_d <= loop_locked_i;
        end
    end

    // a loop already in holdover at release is seen as an entry;
    // the enable register is clear then, so nothing latches
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            holdover_d <= {`DLE_LOOPS{1'b0}};
        end else begin
            holdover_d <= loop_holdover_i;
        end
    end

    always @* begin
        next_enable = enable;
        if (wr_enable) begin
            next_enable = wdata_evt;
        end
    end

    // a new enable gates later edges only, not one seen in the same cycle
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            enable <= `DLE_ENABLE_RST;
        end else begin
            enable <= next_enable;
        end
    end

    genvar k;
    generate
        for (k = 0; k < `DLE_LOOPS; k = k + 1) begin : g_loop
            wire unlock_edge;
            wire hold_entry;
            wire unlocked_now;
            wire holding_now;
            // loss of lock is the falling edge of the lock indicator
            assign unlock_edge = locked_d[k] & ~loop_locked_i[k];
            // holdover entry is the rising edge of the holdover indicator
            assign hold_entry = ~holdover_d[k] & loop_holdover_i[k];
            assign unlocked_now = ~loop_locked_i[k];
            assign holding_now = loop_holdover_i[k];
            // edges, not levels: a loop that stays unlocked does not
            // set its bit again once software has cleared it
            assign event_raw[`DLE_UNLOCK_POS(k)] = unlock_edge;
            assign event_raw[`DLE_HOLD_POS(k)] = hold_entry;
            assign live[`DLE_UNLOCK_POS(k)] = unlocked_now;
            assign live[`DLE_HOLD_POS(k)] = holding_now;
        end
    endgenerate

    generate
        for (k = 0; k < `DLE_EVT_W; k = k + 1) begin : g_bit
            // a masked event is dropped here and never reaches the latch
            assign event_set[k] = event_raw[k] & enable[k];
            // a zero written clears, a one leaves the bit alone
            assign event_clr[k] = wr_latch & clr_mask[k];
            // set outranks a clear in the same cycle so no event is lost
            dle_sticky_bit u_bit (
                .clk_i(clk_i),
                .rst_b_i(rst_b_i),
                .set_i(event_set[k]),
                .clr_i(event_clr[k]),
                .q_o(latch[k])
            );
        end
    endgenerate

    assign loop0_hold_event = latch[`DLE_LOOP0_HOLD];
    assign loop0_unlock_event = latch[`DLE_LOOP0_UNLOCK];
    assign loop1_hold_event = latch[`DLE_LOOP1_HOLD];
    assign loop1_unlock_event = latch[`DLE_LOOP1_UNLOCK];
    assign loop2_hold_event = latch[`DLE_LOOP2_HOLD];
    assign loop2_unlock_event = latch[`DLE_LOOP2_UNLOCK];

    // clearing an enable bit also masks a bit already latched
    assign pending = latch & enable;

    always @* begin
        next_irq = |pending;
    end

    // one cycle behind the latch, but straight from a flop
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= next_irq;
        end
    end

    assign rsvd_zero = `DLE_RSVD_BITS;
    assign latch_view = {
        rsvd_zero,
        loop2_unlock_event,
        loop2_hold_event,
        loop1_unlock_event,
        loop1_hold_event,
        loop0_unlock_event,
        loop0_hold_event
    };
    assign enable_view = {rsvd_zero, enable};
    assign live_view = {rsvd_zero, live};

    // unmapped addresses read zero; with no read the data holds
    always @* begin
        next_rdata = reg_rdata_o;
        if (rd_latch) begin
            next_rdata = latch_view;
        end else if (rd_enable) begin
            next_rdata = enable_view;
        end else if (rd_live) begin
            next_rdata = live_view;
        end else if (rd_unmapped) begin
            next_rdata = `DLE_RDATA_RST;
        end
    end

    // registered so the data stands until the next read
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= `DLE_RDATA_RST;
        end else begin
            reg_rdata_o <= next_rdata;
        end
    end

endmodule // dle_event_latch

// File: testbench/dle_event_latch_monitor.sv
`timescale 1ns/100ps
module dle_event_latch_monitor (
    input wire clk_i,
    input wire rst_b_i,
    input wire [2:0] loop_locked_i,
    input wire [2:0] loop_holdover_i,
    input wire [11:0] reg_addr_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_wdata_i,
    input wire [7:0] reg_rdata_o,
    input wire irq_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (!rst_b_i);
// shadow of the enable register, rebuilt from port writes
reg [5:0] en;
wire [7:0] live = {2'b00, ~loop_locked_i[2], loop_holdover_i[2], ~loop_locked_i[1],
    loop_holdover_i[1], ~loop_locked_i[0], loop_holdover_i[0]};
always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) en <= 6'h00;
    else if (reg_wr_i && reg_addr_i == 12'h025) en <= reg_wdata_i[5:0];
end
unlock_irq_a: assert property ($fell(loop_locked_i[1]) && en[3] |-> ##[1:2] irq_o)
    else $error("lost lock raised no request");
hold_irq_a: assert property ($rose(loop_holdover_i[2]) && en[4] |-> ##[1:2] irq_o)
    else $error("holdover raised no request");
latch_irq_a: assert property (reg_rd_i && reg_addr_i == 12'h022 && !reg_wr_i
    |=> (reg_rdata_o[5:0] & en) == 6'h00 || irq_o) else $error("latched bit without request");
irq_sticky_a: assert property (irq_o && !reg_wr_i && !$past(reg_wr_i) |=> irq_o)
    else $error("request dropped without write");
live_read_a: assert property (reg_rd_i && reg_addr_i == 12'h026
    |=> reg_rdata_o == $past(live)) else $error("live status wrong");
mask_irq_a: assert property (en == 6'h00 |=> !irq_o) else $error("masked request");
clear_irq_a: assert property (reg_wr_i && reg_addr_i == 12'h022 && reg_wdata_i == 8'h00
    && $stable({loop_locked_i, loop_holdover_i}) |=> ##1 !irq_o) else $error("clear kept request");
endmodule // dle_event_latch_monitor
bind dle_event_latch dle_event_latch_monitor mon (.clk_i, .rst_b_i, .loop_locked_i,
    .loop_holdover_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .irq_o);

// File: testbench/dle_event_latch_tb.sv
`timescale 1ns/100ps
module dle_event_latch_tb;
reg clk_i = 0, rst_b_i = 0, reg_wr_i = 0, reg_rd_i = 0;
reg [2:0] loop_locked_i = 3'h7, loop_holdover_i = 3'h0;
reg [11:0] reg_addr_i = 12'h000;
reg [7:0] reg_wdata_i = 8'h00;
wire [7:0] reg_rdata_o;
wire irq_o;
int n_mismatch = 0, n_compared = 0, i, k;
// enable written, latch expected; last row keeps its own event masked
logic [15:0] rows [0:6] = '{16'h0101, 16'h0202, 16'h0404, 16'h0808, 16'h1010, 16'h2020, 16'h3E00};
always #50 clk_i = ~clk_i;
dle_event_latch dut (.clk_i, .rst_b_i, .loop_locked_i, .loop_holdover_i, .reg_addr_i,
    .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .irq_o);
task tally_and_finish;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
endtask
task chk(input [7:0] got, input [7:0] exp);
    n_compared++;
    if (got !== exp) begin
        n_mismatch++;
        $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
endtask
task acc(input w, input [11:0] a, input [7:0] d);
    @(negedge clk_i);
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = {w, !w, a, d};
    @(negedge clk_i);
    {reg_wr_i, reg_rd_i} = 2'b00;
endtask
initial begin
    #200000;
    n_mismatch++;
    tally_and_finish;
end
initial begin
    repeat (20) @(posedge clk_i);
    @(negedge clk_i) rst_b_i = 1;
    acc(0, 12'h022, 0); chk(reg_rdata_o, 8'h00);
    for (i = 0; i < 7; i++) begin
        k = i % 6;
        acc(1, 12'h025, rows[i][15:8]);
        // condition ends again before the read, so only the latch remembers it
        @(negedge clk_i) if (k % 2) loop_locked_i[k/2] = 0; else loop_holdover_i[k/2] = 1;
        @(negedge clk_i) {loop_locked_i, loop_holdover_i} = 6'h38;
        repeat (2) @(negedge clk_i);
        chk({7'h00, irq_o}, {7'h00, |rows[i][7:0]});
        acc(0, 12'h022, 0); chk(reg_rdata_o, rows[i][7:0]);
        acc(1, 12'h022, 8'h00); acc(0, 12'h022, 0); chk(reg_rdata_o, 8'h00);
        repeat (2) @(negedge clk_i);
        chk({7'h00, irq_o}, 8'h00);
    end
    {loop_locked_i, loop_holdover_i} = 6'h14;
    acc(0, 12'h026, 0); chk(reg_rdata_o, 8'h32);
    // those drops are fresh edges with every bit enabled except loop 0 holdover
    acc(0, 12'h022, 0); chk(reg_rdata_o, 8'h32);
    acc(0, 12'h025, 0); chk(reg_rdata_o, 8'h3E);
    // a write to the live register is ignored; a one written keeps its bit
    acc(1, 12'h026, 8'h00);
    acc(1, 12'h022, 8'hFD);
    acc(0, 12'h022, 0); chk(reg_rdata_o, 8'h30);
    // an event in the very cycle of a clearing write still lands
    @(negedge clk_i) begin
        {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'b1, 12'h022, 8'h00};
        loop_locked_i[1] = 0;
    end
    @(negedge clk_i) reg_wr_i = 0;
    acc(0, 12'h022, 0); chk(reg_rdata_o, 8'h08);
    chk({7'h00, irq_o}, 8'h01);
    // reset in mid-run clears latch, enable and request
    rst_b_i = 0;
    @(negedge clk_i) chk({7'h00, irq_o}, 8'h00);
    @(negedge clk_i) rst_b_i = 1;
    acc(0, 12'h022, 0); chk(reg_rdata_o, 8'h00);
    acc(0, 12'h025, 0); chk(reg_rdata_o, 8'h00);
    acc(0, 12'h0FF, 0); chk(reg_rdata_o, 8'h00);
    tally_and_finish;
end
endmodule // dle_event_latch_tb
